// ---- host_cpu_model.sv ----
// Purpose: host processor model driving SRAM-style cycles
// Assumes: straps and resets are driven by the bench
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
`include "host_sram_map.svh"
module host_cpu_model (
	input  wire logic                       clk,
	input  wire logic                       hostClk,
	input  wire logic                       hostWaitN,
	input  wire logic [`HSP_DATA_W-1:0]     hostDataOut,
	input  wire logic                       hostDataOe,
	output logic                            csN,
	output logic                            pgN,
	output logic [`HSP_PIN_ADDR_W-1:0]      addr,
	output logic                            rdN,
	output logic                            wrN,
	output logic [`HSP_LANES-1:0]           laneN,
	output logic [`HSP_DATA_W-1:0]          dataIn
);
	logic [`HSP_DATA_W-1:0] drv;

	// ==========================================
	// shared data wire: device wins while it drives
	assign dataIn = hostDataOe ? hostDataOut : drv;

	initial begin
		csN = 1'b1;
		pgN = 1'b1;
		addr = '0;
		rdN = 1'b1;
		wrN = 1'b1;
		laneN = '1;
		drv = '0;
	end

	task automatic step(input bit s);
		if (s) @(negedge hostClk);
		else @(negedge clk);
	endtask : step

	// ==========================================
	// one word access, held until wait is released
	task automatic access(input bit w, input bit s, input bit p, input logic [19:0] a,
		input logic [3:0] ln, input logic [31:0] wd, output logic [31:0] rd, output bit ok);
		int n;
		bit sw;
		sw = w && s;
		step(sw);
		// sync-mode write inputs move just after a falling host clock edge, all other accesses just after a falling clk edge
		addr <= a;
		laneN <= ~ln;
		drv <= wd;
		if (p) pgN <= 1'b0;
		else csN <= 1'b0;
		if (w) wrN <= 1'b0;
		else rdN <= 1'b0;
		n = 0;
		while (hostWaitN !== 1'b0 && n < 12) begin
			step(sw);
			n++;
		end
		ok = hostWaitN === 1'b0;
		n = 0;
		while (hostWaitN !== 1'b1 && n < 60) begin
			step(sw);
			n++;
		end
		// device drives the data wire only for reads
		ok = ok && hostWaitN === 1'b1 && hostDataOe === !w;
		rd = hostDataOut;
		// address held stable until strobes go away
		csN <= 1'b1;
		pgN <= 1'b1;
		rdN <= 1'b1;
		wrN <= 1'b1;
		addr <= ~a;
		drv <= ~wd;
		laneN <= ln;
		repeat (3) step(sw);
	endtask : access
endmodule : host_cpu_model

// ---- host_link_capture.sv ----
// Purpose: synchronous-mode write capture on the host bus clock
// Assumes: host drives write inputs synchronous to host_bus_clock
// Notes:   toggle handshake toward the core clock domain
`timescale 1ns/1ps
`include "host_sram_map.svh"
module host_link_capture (
	input  wire logic                          host_bus_clock,
	input  wire logic                          rst,
	input  wire logic                          enable,
	input  wire logic                          readBusy,
	input  wire logic                          ackToggle,
	input  wire logic                          hostChipSelectN,
	input  wire logic                          hostPageSelectN,
	input  wire logic [`HSP_PIN_ADDR_W-1:0]    hostAddrBus,
	input  wire logic                          hostWriteStrobeN,
	input  wire logic [`HSP_LANES-1:0]         hostByteWriteN,
	input  wire logic [`HSP_LANES-1:0]         hostByteLaneEnN,
	input  wire logic [`HSP_DATA_W-1:0]        hostDataIn,
	output host_sram_pkg::link_word_t          word,
	output logic                               evtToggle,
	output logic                               linkWaitN
);
	import host_sram_pkg::*;

	// ==========================================
	// crossings into the link domain
	logic [3:0]  syncA_reg;
	logic [3:0]  syncB_reg;
	logic        linkRst;
	logic        linkEn;
	logic        busyS;
	logic        ackS;
	logic        ackSeen_reg;
	link_state_t state_reg;
	link_state_t state_next;
	logic        hit;

	always_ff @(posedge host_bus_clock) begin
		syncA_reg <= {rst, enable, readBusy, ackToggle};
		syncB_reg <= syncA_reg;
	end
	assign linkRst = syncB_reg[3];
	assign linkEn  = syncB_reg[2];
	assign busyS   = syncB_reg[1];
	assign ackS    = syncB_reg[0];

	// RL3 sampled write start
	assign hit = linkEn && !hostWriteStrobeN && !(hostChipSelectN && hostPageSelectN);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			L_IDLE: if (hit) state_next = L_BUSY;
			L_BUSY: if (ackS != ackSeen_reg) state_next = L_DONE;
			L_DONE: if (hostWriteStrobeN) state_next = L_IDLE;
			default: state_next = L_IDLE;
		endcase
	end

	always_ff @(posedge host_bus_clock) begin
		if (linkRst) begin
			state_reg   <= L_IDLE;
			evtToggle   <= 1'b0;
			ackSeen_reg <= 1'b0;
			word        <= '0;
			linkWaitN   <= 1'b1;
		end else begin
			state_reg <= state_next;
			// RL3 capture on host clock
			if (state_reg == L_IDLE && hit) begin
				word.addr   <= hostAddrBus;
				word.data   <= hostDataIn;
				word.byteEn <= ~(hostByteWriteN | hostByteLaneEnN);
				evtToggle   <= ~evtToggle;
			end
			if (state_reg == L_BUSY && ackS != ackSeen_reg)
				ackSeen_reg <= ackS;
			// RL8 wait held while busy
			linkWaitN <= !(state_next == L_BUSY || busyS);
		end
	end

	// RL3 wait low after capture
	a_link_wait_low: assert property (@(posedge host_bus_clock) disable iff (linkRst)
		(state_reg == L_IDLE && hit) |=> !linkWaitN && state_reg == L_BUSY)
		else $error("link wait not low after capture");

	// RL8 wait released after ack
	a_link_wait_release: assert property (@(posedge host_bus_clock) disable iff (linkRst)
		(state_reg == L_BUSY && ackS != ackSeen_reg && !busyS) |=> linkWaitN)
		else $error("link wait not released after ack");

endmodule : host_link_capture

// ---- host_sram_map.svh ----
// Purpose: constants for the host SRAM-style port
// Assumes: included by bare name
// Notes:   widths, window layout and reset values
`ifndef HOST_SRAM_MAP_SVH
`define HOST_SRAM_MAP_SVH

// ==========================================
// widths
`define HSP_PIN_ADDR_W  20
`define HSP_OFS_W       21
`define HSP_DATA_W      32
`define HSP_LANES       4
`define HSP_SYS_ADDR_W  32

// ==========================================
// window layout
`define HSP_WIN_BASE    32'h0000_0000
`define HSP_WIN_BYTES   22'h20_0000
`define HSP_PERIPH_SIZE 21'h00_D000
`define HSP_PERIPH_BASE 21'h1F_3000

// ==========================================
// reset values
`define HSP_DATA_RST    32'h0000_0000
`define HSP_ADDR_RST    21'h00_0000
`define HSP_LANE_RST    4'h0

`endif

// ---- host_sram_pkg.sv ----
// Purpose: types shared by the host SRAM-style port
// Assumes: host_sram_map.svh holds the numbers
// Notes:   structs carry grouped signals
`include "host_sram_map.svh"
package host_sram_pkg;

	// ==========================================
	// request toward the internal bus
	typedef struct packed {
		logic                          write;
		logic                          periph;
		logic [`HSP_SYS_ADDR_W-1:0]    addr;
		logic [`HSP_DATA_W-1:0]        data;
		logic [`HSP_LANES-1:0]         byteEn;
	} host_req_t;

	// ==========================================
	// write captured on the host bus clock
	typedef struct packed {
		logic [`HSP_PIN_ADDR_W-1:0]    addr;
		logic [`HSP_DATA_W-1:0]        data;
		logic [`HSP_LANES-1:0]         byteEn;
	} link_word_t;

	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_REQ  = 2'b01,
		P_RESP = 2'b10,
		P_DONE = 2'b11
	} port_state_t;

	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_BUSY = 2'b01,
		L_DONE = 2'b10
	} link_state_t;

endpackage : host_sram_pkg

// ---- host_sram_port.sv ----
// Purpose: host SRAM-style slave port into a 2 Mbyte internal window
// Assumes: internal bus answers each request once with rspValid
// Notes:   mode straps are caught once after reset release
`timescale 1ns/1ps
`include "host_sram_map.svh"

// How it works
// RL1 - decode 2 Mbyte window for host access
// RL2 - top 52 Kbytes flagged as peripheral area
// RL3 - sync mode: writes sampled on host clock
// RL4 - reads, error output always on async path
// RL5 - host keeps read address stable
// RL6 - strap selects synchronous or asynchronous mode
// RL7 - straps fixed before reset release, iface pin high
// RL8 - wait low until access serviced
module host_sram_port (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          host_bus_clock,
	input  wire logic                          power_on_reset_n,
	input  wire logic                          sys_reset_n,
	input  wire logic                          iface_select_pin,
	input  wire logic                          sync_mode_select,
	input  wire logic                          host_chip_select_n,
	input  wire logic                          host_page_select_n,
	input  wire logic [`HSP_PIN_ADDR_W-1:0]    host_addr_bus,
	input  wire logic                          host_read_strobe_n,
	input  wire logic                          host_write_strobe_n,
	input  wire logic [`HSP_LANES-1:0]         host_byte_write_n,
	input  wire logic [`HSP_LANES-1:0]         host_byte_lane_en_n,
	input  wire logic [`HSP_DATA_W-1:0]        host_data_in,
	output logic      [`HSP_DATA_W-1:0]        host_data_out,
	output logic                               host_data_oe,
	output logic                               host_wait_n,
	output logic                               host_error_n,
	output host_sram_pkg::host_req_t           req,
	output logic                               reqValid,
	input  wire logic                          reqReady,
	input  wire logic                          rspValid,
	input  wire logic [`HSP_DATA_W-1:0]        rspData,
	input  wire logic                          rspError
);
	import host_sram_pkg::*;

	// eight single-bit pins ride along with the lanes, data and address
	localparam int PW = 2 * `HSP_LANES + `HSP_DATA_W + `HSP_PIN_ADDR_W + 8;

	// ==========================================
	// pin synchronisers
	logic [PW-1:0]               syncA_reg;
	logic [PW-1:0]               syncB_reg;
	logic                        porN;
	logic                        sysN;
	logic                        ifSel;
	logic                        modeSel;
	logic                        csN;
	logic                        pgN;
	logic                        rdN;
	logic                        wrN;
	logic [`HSP_LANES-1:0]       bwN;
	logic [`HSP_LANES-1:0]       beN;
	logic [`HSP_DATA_W-1:0]      dIn;
	logic [`HSP_PIN_ADDR_W-1:0]  aIn;

	always_ff @(posedge clk) begin
		syncA_reg <= {power_on_reset_n, sys_reset_n, iface_select_pin, sync_mode_select,
			host_chip_select_n, host_page_select_n, host_read_strobe_n,
			host_write_strobe_n, host_byte_write_n, host_byte_lane_en_n,
			host_data_in, host_addr_bus};
		syncB_reg <= syncA_reg;
	end
	assign {porN, sysN, ifSel, modeSel, csN, pgN, rdN, wrN, bwN, beN, dIn, aIn} = syncB_reg;

	// ==========================================
	// reset and mode straps
	logic coreRst;
	logic strapDone_reg;
	logic syncMode_reg;
	logic ifaceEn_reg;

	assign coreRst = rst || !porN || !sysN;

	// RL6 strap caught after release
	always_ff @(posedge clk) begin
		if (coreRst) begin
			strapDone_reg <= 1'b0;
			syncMode_reg  <= 1'b0;
			ifaceEn_reg   <= 1'b0;
		end else if (!strapDone_reg) begin
			strapDone_reg <= 1'b1;
			syncMode_reg  <= modeSel;
			ifaceEn_reg   <= ifSel;
		end
	end

	// ==========================================
	// synchronous-mode write link
	link_word_t  linkWord;
	logic        linkToggle;
	logic        linkWaitN;
	logic        ackToggle_reg;
	logic [2:0]  evtSync_reg;
	logic        linkEvt;
	logic        asyncWaitN_reg;

	host_link_capture u_link (
		.host_bus_clock  (host_bus_clock),
		.rst             (coreRst),
		.enable          (syncMode_reg && ifaceEn_reg && strapDone_reg),
		.readBusy        (!asyncWaitN_reg),
		.ackToggle       (ackToggle_reg),
		.hostChipSelectN (host_chip_select_n),
		.hostPageSelectN (host_page_select_n),
		.hostAddrBus     (host_addr_bus),
		.hostWriteStrobeN(host_write_strobe_n),
		.hostByteWriteN  (host_byte_write_n),
		.hostByteLaneEnN (host_byte_lane_en_n),
		.hostDataIn      (host_data_in),
		.word            (linkWord),
		.evtToggle       (linkToggle),
		.linkWaitN       (linkWaitN)
	);

	always_ff @(posedge clk) begin
		if (coreRst)
			evtSync_reg <= 3'h0;
		else
			evtSync_reg <= {evtSync_reg[1:0], linkToggle};
	end
	assign linkEvt = evtSync_reg[2] ^ evtSync_reg[1];

	// ==========================================
	// access decode
	logic                    active;
	logic                    selected;
	logic                    readStart;
	logic                    pinWriteStart;
	logic                    writeStart;
	logic [`HSP_OFS_W-1:0]   startOfs;
	logic [`HSP_OFS_W-1:0]   curOfs_reg;
	logic                    strobeOff;

	function automatic logic isPeriph(input logic [`HSP_OFS_W-1:0] ofs);
		isPeriph = ofs >= `HSP_PERIPH_BASE;
	endfunction

	assign active   = strapDone_reg && ifaceEn_reg;
	assign selected = !(csN && pgN);
	// RL4 read path always synchronised
	assign readStart     = active && selected && !rdN;
	// RL3 pin writes only in async mode
	assign pinWriteStart = active && selected && !wrN && !syncMode_reg;
	assign writeStart    = pinWriteStart || (active && syncMode_reg && linkEvt);
	assign startOfs      = (syncMode_reg && linkEvt && !readStart) ?
		{linkWord.addr, 1'b0} : {aIn, 1'b0};
	assign strobeOff     = rdN && wrN;

	// ==========================================
	// access engine
	port_state_t state_reg;
	port_state_t state_next;
	logic        curWrite_reg;
	logic        fromLink_reg;
	logic        errFlag_reg;

	function automatic logic fromLink_next();
		fromLink_next = (state_reg == P_IDLE) ? (!readStart && !pinWriteStart) : fromLink_reg;
	endfunction : fromLink_next

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			P_IDLE: if (readStart || writeStart) state_next = P_REQ;
			P_REQ:  if (reqReady) state_next = P_RESP;
			P_RESP: if (rspValid) state_next = fromLink_reg ? P_IDLE : P_DONE;
			P_DONE: if (strobeOff || !selected) state_next = P_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (coreRst) begin
			state_reg      <= P_IDLE;
			curWrite_reg   <= 1'b0;
			fromLink_reg   <= 1'b0;
			curOfs_reg     <= `HSP_ADDR_RST;
			req            <= '0;
			ackToggle_reg  <= 1'b0;
			host_data_out  <= `HSP_DATA_RST;
			errFlag_reg    <= 1'b0;
			asyncWaitN_reg <= 1'b1;
			host_data_oe   <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == P_IDLE && (readStart || writeStart)) begin
				curWrite_reg <= !readStart;
				fromLink_reg <= !readStart && !pinWriteStart;
				curOfs_reg   <= startOfs;
				// RL1 window offset onto base
				req.addr     <= `HSP_WIN_BASE | {11'h000, startOfs};
				// RL2 peripheral area flag
				req.periph   <= isPeriph(startOfs);
				req.write    <= !readStart;
				req.data     <= (syncMode_reg && !readStart) ? linkWord.data : dIn;
				req.byteEn   <= readStart ? ~beN : ((syncMode_reg) ? linkWord.byteEn : ~(bwN | beN));
				errFlag_reg  <= 1'b0;
			end
			if (state_reg == P_RESP && rspValid) begin
				if (!curWrite_reg)
					host_data_out <= rspData;
				// RL4 error output from core
				if (rspError)
					errFlag_reg <= 1'b1;
				if (fromLink_reg)
					ackToggle_reg <= ~ackToggle_reg;
			end
			// RL8 wait held while serviced
			asyncWaitN_reg <= !((state_next == P_REQ || state_next == P_RESP) && !fromLink_next());
			host_data_oe   <= (state_next != P_IDLE) && !rdN &&
				!(state_next == P_REQ ? !readStart && state_reg == P_IDLE : curWrite_reg);
		end
	end

	assign reqValid = (state_reg == P_REQ);
	// RL3 wait from host clock in sync mode
	assign host_wait_n  = syncMode_reg ? linkWaitN : asyncWaitN_reg;
	assign host_error_n = !errFlag_reg;

	// ==========================================
	// checks
	// RL1 window base
	a_window_base: assert property (@(posedge clk) disable iff (coreRst)
		reqValid |-> req.addr[31:21] == `HSP_WIN_BASE >> 21)
		else $error("request outside host window");

	// RL2 peripheral flag
	a_periph_flag: assert property (@(posedge clk) disable iff (coreRst)
		reqValid |-> req.periph == (curOfs_reg >= `HSP_PERIPH_BASE))
		else $error("peripheral flag wrong");

	// RL3 pin strobe ignored in sync mode
	a_sync_pin_ignored: assert property (@(posedge clk) disable iff (coreRst)
		(state_reg == P_IDLE && syncMode_reg && !readStart && !linkEvt) |=> state_reg == P_IDLE)
		else $error("sync mode took write from pins");

	// RL4 read started from synchronised pins
	a_read_start: assert property (@(posedge clk) disable iff (coreRst)
		(state_reg == P_IDLE && readStart) |=> reqValid && !req.write)
		else $error("read not started");

	// RL4 error output follows response
	a_error_out: assert property (@(posedge clk) disable iff (coreRst)
		(state_reg == P_RESP && rspValid && rspError) |=> !host_error_n)
		else $error("error output not asserted");

	// RL6 mode fixed after strap
	a_mode_static: assert property (@(posedge clk) disable iff (coreRst)
		strapDone_reg |=> $stable(syncMode_reg) && $stable(ifaceEn_reg))
		else $error("mode changed during operation");

	// RL8 read data valid when wait releases
	a_read_release: assert property (@(posedge clk) disable iff (coreRst)
		(state_reg == P_RESP && rspValid && !curWrite_reg) |=>
			asyncWaitN_reg && host_data_out == $past(rspData))
		else $error("wait released without read data");

	// RL8 wait low while request pending
	a_wait_busy: assert property (@(posedge clk) disable iff (coreRst)
		(state_reg == P_REQ && !fromLink_reg) [*2] |-> !asyncWaitN_reg)
		else $error("wait high while serviced");

endmodule : host_sram_port

// ---- host_sram_port_tb_top.sv ----
// Purpose: self-checking bench for the host SRAM-style port
// Assumes: host model drives pins, bench answers the internal bus
// Notes:   random values from xorshift seeded with 91
`timescale 1ns/1ps
`include "host_sram_map.svh"
module host_sram_port_tb_top;
	import host_sram_pkg::*;
	localparam int PERIPH_LO = 2*1024*1024 - 52*1024;
	localparam logic [19:0] CORNER [4] = '{20'h00000, 20'hF97FF, 20'hF9800, 20'hFFFFF};
	logic        clk, hclk, rst, porN, sysN, ifSel, syncSel, csN, pgN, rdN, wrN;
	logic        waitN, errN, oe, reqValid, reqReady, rspValid, rspError, errNext;
	logic [19:0] addr;
	logic [3:0]  laneN;
	logic [31:0] dataIn, dataOut, rspData, seed = 32'h5B;
	host_req_t   req, lastReq;
	int          nReq = 0, nRsp = 0, dly = 0, n_fail = 0, check_count = 0;

	host_cpu_model host (.clk(clk), .hostClk(hclk), .hostWaitN(waitN), .hostDataOut(dataOut),
		.hostDataOe(oe), .csN(csN), .pgN(pgN), .addr(addr), .rdN(rdN), .wrN(wrN),
		.laneN(laneN), .dataIn(dataIn));
	host_sram_port dut (.clk(clk), .rst(rst), .host_bus_clock(hclk), .power_on_reset_n(porN),
		.sys_reset_n(sysN), .iface_select_pin(ifSel), .sync_mode_select(syncSel),
		.host_chip_select_n(csN), .host_page_select_n(pgN), .host_addr_bus(addr),
		.host_read_strobe_n(rdN), .host_write_strobe_n(wrN), .host_byte_write_n(laneN),
		.host_byte_lane_en_n(laneN), .host_data_in(dataIn), .host_data_out(dataOut),
		.host_data_oe(oe), .host_wait_n(waitN), .host_error_n(errN), .req(req),
		.reqValid(reqValid), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.rspError(rspError));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		hclk = 1'b0;
		#13;
		forever #40 hclk = ~hclk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]} ^ 32'h5A3C_96E1;
	endfunction : pat

	// ==========================================
	// internal bus responder with random stalls
	always @(posedge clk) begin
		if (reqValid === 1'b1 && reqReady === 1'b1) begin
			lastReq <= req;
			nReq <= nReq + 1;
		end
	end
	always @(negedge clk) begin
		reqReady <= xs() > 32'h5000_0000;
		if (nReq != nRsp && dly == 0) begin
			rspValid <= 1'b1;
			rspData <= pat(lastReq.addr);
			rspError <= errNext;
			nRsp <= nRsp + 1;
			dly <= xs() % 4;
		end else begin
			rspValid <= 1'b0;
			if (nReq != nRsp) dly <= dly - 1;
		end
	end

	task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk32

	task automatic chk1(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : chk1

	// ==========================================
	// straps settle before reset lets go
	task automatic doReset(input logic s, input logic f);
		@(negedge clk);
		rst = 1'b1;
		porN = 1'b0;
		sysN = 1'b0;
		// straps fixed while reset is held
		syncSel = s;
		ifSel = f;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		porN = 1'b1;
		sysN = 1'b1;
		repeat (6) @(negedge clk);
	endtask : doReset

	task automatic run(input bit w, input logic [19:0] a, input bit err);
		logic [31:0] wd, rd, ea;
		logic [3:0]  ln;
		bit          ok;
		int          n0;
		wd = xs();
		ln = wd[7:4] == 4'h0 ? 4'hF : wd[7:4];
		ea = `HSP_WIN_BASE + {11'h000, a, 1'b0};
		errNext = err;
		n0 = nReq;
		host.access(w, syncSel, wd[9], a, ln, wd, rd, ok);
		chk1("wait handshake", 1'b1, ok);
		chk32("request count", n0 + 1, nReq);
		chk1("request write", w, lastReq.write);
		chk1("periph flag", ea[20:0] >= PERIPH_LO, lastReq.periph);
		chk32("request addr", ea, lastReq.addr);
		chk32("request lanes", {28'h0, ln}, {28'h0, lastReq.byteEn});
		if (w) chk32("write data", wd, lastReq.data);
		else chk32("read data", pat(ea), rd);
		chk1("error out", ~err, errN);
	endtask : run

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#400000;
		n_fail++;
		tally_and_finish();
	end

	initial begin
		logic [31:0] r, rd;
		bit          ok;
		int          n0;
		rst = 1'b1;
		porN = 1'b0;
		sysN = 1'b0;
		ifSel = 1'b1;
		syncSel = 1'b0;
		reqReady = 1'b0;
		rspValid = 1'b0;
		rspData = '0;
		rspError = 1'b0;
		errNext = 1'b0;
		repeat (3) @(negedge clk);
		for (int m = 0; m < 2; m++) begin
			doReset(m[0], 1'b1);
			for (int i = 0; i < 14; i++) begin
				r = xs();
				run(i[0], i < 8 ? CORNER[i >> 1] : r[20:1], i == 5 || r[3:0] == 4'h0);
			end
		end
		doReset(1'b0, 1'b0);
		n0 = nReq;
		host.access(1'b0, 1'b0, 1'b0, 20'h00010, 4'hF, 32'h0, rd, ok);
		chk1("refused wait", 1'b0, ok);
		chk32("refused request", n0, nReq);
		tally_and_finish();
	end
endmodule : host_sram_port_tb_top
